// ### rtl/abc_defines.svh
// constants of the area bus configuration block: offsets, fields, resets
// assumes a 32-bit apb slave port and five chip-select areas (0, 3, 4, 5, 6)
`ifndef ABC_DEFINES_SVH
`define ABC_DEFINES_SVH

// register byte offsets on the apb port
`define ABC_OFF_AREA0 8'h00
`define ABC_OFF_AREA3 8'h04
`define ABC_OFF_AREA4 8'h08
`define ABC_OFF_AREA5 8'h0C
`define ABC_OFF_AREA6 8'h10
`define ABC_OFF_STATUS 8'h14
// highest mapped word index
`define ABC_LAST_INDEX 3'h5
// number of chip-select areas
`define ABC_AREAS 5

// field positions inside area_bus_config
`define ABC_XRR_HI 20
`define ABC_XRR_LO 19
`define ABC_SRR_HI 17
`define ABC_SRR_LO 16
`define ABC_KIND_HI 15
`define ABC_KIND_LO 12
`define ABC_WID_HI 10
`define ABC_WID_LO 9

// reset value and writable bits of area_bus_config
`define ABC_CFG_RESET 32'h001B_0600
`define ABC_CFG_WMASK 32'h001B_F600

// width codes
`define ABC_WID_32 2'h3
`define ABC_WID_16 2'h2

`endif

// ### rtl/abc_pkg.sv
// types of the area bus configuration block
// assumes abc_defines.svh supplies the numbers
package abc_pkg;
    // sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACCESS} abc_state_e;
    // memory kinds an area may hold
    typedef enum logic [3:0] {
        KIND_NORMAL = 4'h0,
        KIND_BYTE_SRAM = 4'h3,
        KIND_SDRAM = 4'h4,
        KIND_PCMCIA = 4'h5
    } abc_kind_e;
endpackage

// ### rtl/abc_gap_counter.sv
// down counter that times the idle cycles between two reads
// assumes the sequencer loads it only with a non-zero count
`timescale 1ns/1ps
module abc_gap_counter
    import abc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [2:0] load_val,
    output logic [2:0] remain
);
    logic [2:0] cnt_q; // idle cycles still to run
    logic [2:0] cnt_d;

    // next count: load wins, otherwise count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
        end
    end

    // count register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign remain = cnt_q;
endmodule // abc_gap_counter

// ### rtl/abc_top.sv
// area bus configuration registers and read-to-read idle sequencer
// assumes an apb master on CLK and a requester that holds REQ_* until REQ_READY
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "abc_defines.svh"
module abc_top
    import abc_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic BUS_WIDTH_MODE_PIN,
    input wire logic REQ_VALID,
    input wire logic [2:0] REQ_AREA,
    input wire logic REQ_READ,
    output logic REQ_READY,
    output logic [4:0] CS_N,
    output logic RD_N,
    output logic WE_N,
    output logic [3:0] ACC_KIND,
    output logic [1:0] ACC_WIDTH
);
    logic [31:0] cfg_q [`ABC_AREAS]; // area_bus_config per area
    logic [31:0] cfg_d [`ABC_AREAS];
    logic cap_done_q; // area 0 width taken from the pin
    logic cap_done_d;
    abc_state_e state_q; // sequencer state
    abc_state_e state_d;
    logic [2:0] area_q; // area of the cycle in flight
    logic [2:0] area_d;
    logic read_q; // direction of the cycle in flight
    logic read_d;
    logic last_valid_q; // a previous cycle exists
    logic last_valid_d;
    logic last_read_q; // previous cycle was a read
    logic last_read_d;
    logic [2:0] last_area_q; // area of the previous cycle
    logic [2:0] last_area_d;
    logic [2:0] gap_remain; // counter state
    logic gap_load;
    logic [2:0] gap_val;
    logic [2:0] idx; // apb word index
    logic mapped; // apb address hits a register
    logic apb_wr;
    logic take; // request accepted this cycle
    logic same_area;
    logic [1:0] gap_code;

    // idle code to cycle count: the top code jumps to four, not three
    function automatic logic [2:0] idle_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: idle_cycles = 3'h0;
            2'h1: idle_cycles = 3'h1;
            2'h2: idle_cycles = 3'h2;
            2'h3: idle_cycles = 3'h4;
        endcase
    endfunction

    // apb decode: zero wait states, unmapped words answer with an error
    assign idx = PADDR[4:2];
    assign mapped = (PADDR[7:5] == 3'h0) && (PADDR[1:0] == 2'h0) && (idx <= `ABC_LAST_INDEX);
    assign apb_wr = PSEL && PENABLE && PWRITE && mapped;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    // read mux; reserved bits are cleared by ANDing the stored value with ABC_CFG_WMASK
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PSEL && mapped && !PWRITE) begin
            if (idx == `ABC_LAST_INDEX) begin
                // status: gap count, state, last area
                PRDATA = {21'h0, last_area_q, 1'b0, gap_remain, 2'h0, state_q == ST_GAP, last_read_q};
            end else begin
                PRDATA = cfg_q[idx] & `ABC_CFG_WMASK;
            end
        end
    end

    // register next values; area 0 width never follows software
    always_comb begin
        for (int i = 0; i < `ABC_AREAS; i++) begin
            cfg_d[i] = cfg_q[i];
            if (apb_wr && (idx == 3'(i))) begin
                cfg_d[i] = PWDATA & `ABC_CFG_WMASK;
            end
        end
        // keep the pin-derived width in area 0
        cfg_d[0][`ABC_WID_HI:`ABC_WID_LO] = cfg_q[0][`ABC_WID_HI:`ABC_WID_LO];
        cap_done_d = 1'b1;
        if (!cap_done_q) begin
            // first edge after reset release samples the strap
            cfg_d[0][`ABC_WID_HI:`ABC_WID_LO] = BUS_WIDTH_MODE_PIN ? `ABC_WID_32 : `ABC_WID_16;
        end
    end

    // configuration registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < `ABC_AREAS; i++) begin
                cfg_q[i] <= `ABC_CFG_RESET;
            end
            cap_done_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            cap_done_q <= cap_done_d;
        end
    end

    // gap choice uses the previous area's fields, since idle follows its access
    assign same_area = (REQ_AREA == last_area_q);
    assign gap_code = same_area
        ? cfg_q[last_area_q][`ABC_SRR_HI:`ABC_SRR_LO]
        : cfg_q[last_area_q][`ABC_XRR_HI:`ABC_XRR_LO];
    assign take = (state_q == ST_IDLE) && REQ_VALID && (REQ_AREA < 3'(`ABC_AREAS));

    // sequencer next state
    always_comb begin
        state_d = state_q;
        area_d = area_q;
        read_d = read_q;
        last_valid_d = last_valid_q;
        last_read_d = last_read_q;
        last_area_d = last_area_q;
        gap_load = 1'b0;
        gap_val = idle_cycles(gap_code);
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    area_d = REQ_AREA;
                    read_d = REQ_READ;
                    if (last_valid_q && last_read_q && REQ_READ && (gap_val != 3'h0)) begin
                        gap_load = 1'b1;
                        state_d = ST_GAP;
                    end else begin
                        state_d = ST_ACCESS;
                    end
                end
            end
            ST_GAP: begin
                // leave when the last idle cycle runs
                if (gap_remain == 3'h1) begin
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                last_valid_d = 1'b1;
                last_read_d = read_q;
                last_area_d = area_q;
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            area_q <= 3'h0;
            read_q <= 1'b0;
            last_valid_q <= 1'b0;
            last_read_q <= 1'b0;
            last_area_q <= 3'h0;
        end else begin
            state_q <= state_d;
            area_q <= area_d;
            read_q <= read_d;
            last_valid_q <= last_valid_d;
            last_read_q <= last_read_d;
            last_area_q <= last_area_d;
        end
    end

    // idle timer
    abc_gap_counter u_gap (
        .clk(CLK),
        .rst_n(RESET_N),
        .load(gap_load),
        .load_val(gap_val),
        .remain(gap_remain)
    );

    // strobes only in the access cycle, so idle cycles stay quiet
    always_comb begin
        CS_N = 5'h1F;
        RD_N = 1'b1;
        WE_N = 1'b1;
        ACC_KIND = 4'h0;
        ACC_WIDTH = 2'h0;
        REQ_READY = 1'b0;
        if (state_q == ST_ACCESS) begin
            CS_N[area_q] = 1'b0;
            RD_N = !read_q;
            WE_N = read_q;
            REQ_READY = 1'b1;
            ACC_KIND = cfg_q[area_q][`ABC_KIND_HI:`ABC_KIND_LO];
            ACC_WIDTH = cfg_q[area_q][`ABC_WID_HI:`ABC_WID_LO];
        end
    end

    // read pair to another area with code 11 idles exactly four cycles
    cross_gap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        take && last_valid_q && last_read_q && REQ_READ && !same_area
        && cfg_q[last_area_q][`ABC_XRR_HI:`ABC_XRR_LO] == 2'h3
        |=> (state_q == ST_GAP) [*4] ##1 (state_q == ST_ACCESS))
        else $error("cross-area read gap is not four cycles");
    // read pair in one area with code 01 idles exactly one cycle
    same_gap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        take && last_valid_q && last_read_q && REQ_READ && same_area
        && cfg_q[last_area_q][`ABC_SRR_HI:`ABC_SRR_LO] == 2'h1
        |=> (state_q == ST_GAP) ##1 (state_q == ST_ACCESS))
        else $error("same-area read gap is not one cycle");
    // code 00 or a non-read pair goes straight to the access
    no_gap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        take && (gap_code == 2'h0 || !REQ_READ || !last_read_q) |=> state_q == ST_ACCESS)
        else $error("idle inserted where none is due");
    // kind follows the selected area
    kind_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        state_q == ST_ACCESS |-> ACC_KIND == cfg_q[area_q][`ABC_KIND_HI:`ABC_KIND_LO]
        && !CS_N[area_q])
        else $error("memory kind does not match area");
    // width follows the selected area
    width_out_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        state_q == ST_ACCESS |-> ACC_WIDTH == cfg_q[area_q][`ABC_WID_HI:`ABC_WID_LO])
        else $error("bus width does not match area");
    // software cannot move area 0 width
    area0_width_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        cap_done_q && apb_wr && idx == 3'h0
        |=> $stable(cfg_q[0][`ABC_WID_HI:`ABC_WID_LO]))
        else $error("area 0 width changed by a write");
    // strap sampled at the first edge after reset; keyed on the done flag rising,
    // since the release edge itself still sees the flop in reset
    strap_cap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(cap_done_q)
        |-> cfg_q[0][`ABC_WID_HI:`ABC_WID_LO] == ($past(BUS_WIDTH_MODE_PIN) ? 2'h3 : 2'h2))
        else $error("area 0 width not taken from the pin");
    // reserved bits of a config read are zero
    reserved_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        PSEL && !PWRITE && mapped && idx != `ABC_LAST_INDEX |-> (PRDATA & ~`ABC_CFG_WMASK) == 32'h0)
        else $error("reserved bits read non-zero");
    // quiet bus during idle cycles
    idle_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        state_q != ST_ACCESS |-> CS_N == 5'h1F && RD_N && WE_N && !REQ_READY)
        else $error("bus active during idle");
endmodule // abc_top

// ### sim/abc_mem_model.sv
// partner model: memories hanging on the five chip-select areas
// assumes active-low selects and strobes, one access cycle each
`timescale 1ns/1ps
module abc_mem_model (
    input wire logic clk,
    input wire logic [4:0] cs_n,
    input wire logic rd_n,
    input wire logic we_n,
    output int hits,
    output int faults
);
    int hit_cnt = 0; // access cycles seen, counters start clean
    int fault_cnt = 0; // protocol breaks seen
    logic [4:0] sel; // selects, active high
    assign sel = ~cs_n;

    // one select and exactly one strobe per access; no strobe while deselected
    always @(posedge clk) begin
        if (cs_n != 5'h1F) begin
            hit_cnt <= hit_cnt + 1;
            // two selects at once would make two memories fight
            if (((sel & (sel - 5'h1)) != 5'h0) || rd_n == we_n) begin
                fault_cnt <= fault_cnt + 1;
            end
        end else if (!rd_n || !we_n) begin
            fault_cnt <= fault_cnt + 1;
        end
    end
    assign hits = hit_cnt;
    assign faults = fault_cnt;
endmodule // abc_mem_model

// ### sim/tb_top.sv
// self-checking bench of the area bus configuration block
// assumes apb on CLK with zero wait states and one strap pin
`timescale 1ns/1ps
`include "abc_defines.svh"
module tb_top
    import abc_pkg::*;
();
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, pin = 1'h1;
    logic rv = 1'h0, rrd = 1'h0, pready, perr, rdy, rd_n, we_n;
    logic [7:0] pa = 8'h0;
    logic [31:0] pwd = 32'h0, prd, q, rnd = 32'h6253587A;
    logic [2:0] ra = 3'h0;
    logic [4:0] cs_n;
    logic [3:0] kind;
    logic [1:0] wid;
    logic e;
    logic prev_rd; // last access was a read
    logic [31:0] cfg[5]; // expected register contents
    abc_kind_e kinds[4] = '{KIND_NORMAL, KIND_BYTE_SRAM, KIND_SDRAM, KIND_PCMCIA};
    int fails = 0, checks = 0, cyc = 0, nreq = 0, prev_i = 0, hits, faults;
    logic [7:0] pa_bad[3] = '{8'h18, 8'h20, 8'h02}; // unmapped, out of range, misaligned

    abc_top i_abc_top (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready),
        .PSLVERR(perr), .BUS_WIDTH_MODE_PIN(pin), .REQ_VALID(rv), .REQ_AREA(ra),
        .REQ_READ(rrd), .REQ_READY(rdy), .CS_N(cs_n), .RD_N(rd_n), .WE_N(we_n),
        .ACC_KIND(kind), .ACC_WIDTH(wid));
    abc_mem_model i_abc_mem_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .we_n(we_n),
        .hits(hits), .faults(faults));

    // 100 ns period
    always #50 clk = ~clk;

    // hang guard, far above the roughly 850 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            give_verdict();
        end
    end

    // galois shift register for repeatable stimulus
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'h0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction

    // idle code to cycles
    function automatic int gap(input logic [1:0] c);
        return (c == 2'h3) ? 4 : int'(c);
    endfunction

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prd;
        e = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask

    // one access; checks gap length, quiet gap and the access cycle
    task automatic req(input int i, input logic r);
        int n;
        int g;
        g = 0;
        if (prev_rd && r) begin
            g = gap(i == prev_i ? cfg[prev_i][17:16] : cfg[prev_i][20:19]);
        end
        @(posedge clk);
        rv <= 1'h1;
        ra <= 3'(i);
        rrd <= r;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (rdy !== 1'h1) cmp({cs_n, rd_n, we_n}, 7'h7F, "quiet");
        end while (rdy !== 1'h1);
        cmp({cs_n, rd_n, we_n, kind, wid},
            {~(5'h1 << i), ~r, r, cfg[i][15:12], cfg[i][10:9]}, "acc");
        cmp(n, 2 + g, "gap");
        rv <= 1'h0;
        prev_i = i;
        prev_rd = r;
        nreq++;
    endtask

    // program all areas with legal random settings, then read back
    task automatic setup(input int r);
        logic [1:0] w;
        abc_kind_e k;
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            k = kinds[(i + r) % 4];
            w = (k == KIND_PCMCIA || !(rnd[0] || k == KIND_SDRAM)) ? 2'h1 : 2'h3;
            cfg[i] = {11'h0, rnd[20:19], 1'h0, rnd[17:16], k, 1'h0, w, 9'h0};
            apb(1'h1, 8'(i * 4), cfg[i]);
            if (i == 0) cfg[0][10:9] = pin ? 2'h3 : 2'h2;
            apb(1'h0, 8'(i * 4), 32'h0);
            cmp(q, cfg[i], "cfg");
        end
    endtask

    initial begin
        for (int p = 1; p >= 0; p--) begin
            pin <= p[0];
            rst_n <= 1'h0;
            repeat (12) @(posedge clk);
            rst_n <= 1'h1;
            prev_rd = 1'h0;
            for (int i = 0; i < 5; i++) begin
                cfg[i] = (i == 0 && p == 0) ? 32'h001B0400 : `ABC_CFG_RESET;
                apb(1'h0, 8'(i * 4), 32'h0);
                cmp(q, cfg[i], "reset");
            end
            // reset codes give four idle cycles both ways
            req(0, 1'h1);
            req(0, 1'h1);
            req(1, 1'h1);
            req(1, 1'h0);
            req(1, 1'h1);
            for (int r = 0; r < 6; r++) begin
                setup(r);
                repeat (8) begin
                    rnd = lfsr(rnd);
                    req(int'(rnd % 5), rnd[3]);
                end
            end
            // unmapped places answer with an error and read zero
            apb(1'h1, 8'h18, 32'h001BF600);
            cmp(e, 1'h1, "unmapped write");
            foreach (pa_bad[j]) begin
                apb(1'h0, pa_bad[j], 32'h0);
                cmp(e, 1'h1, "unmapped err");
                cmp(q, 32'h0, "unmapped");
            end
            apb(1'h0, 8'h08, 32'h0);
            cmp(q, cfg[2], "kept");
            // status ignores writes and shows the last access once idle
            apb(1'h1, `ABC_OFF_STATUS, 32'hFFFFFFFF);
            cmp(e, 1'h0, "status write");
            apb(1'h0, `ABC_OFF_STATUS, 32'h0);
            cmp(q, {21'h0, 3'(prev_i), 7'h0, prev_rd}, "status");
        end
        cmp(hits, nreq, "hits");
        cmp(faults, 0, "faults");
        give_verdict();
    end
endmodule // tb_top
